// File: verilog/intc_regs_pkg.sv
package intc_regs_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int NUM_SRC = 5;
    localparam int PRIO_W = 3;
    localparam int SRC_W = 3;
    localparam int IDX_W = 8;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CONTROL_ONE = 8'h80;
    localparam logic [IDX_W-1:0] IDX_ENABLE_ONE = 8'h96;
    localparam logic [IDX_W-1:0] IDX_ENABLE_FOUR = 8'h9C;
    localparam logic [IDX_W-1:0] IDX_ENABLE_FIVE = 8'h9E;
    localparam logic [IDX_W-1:0] IDX_PRIORITY_ONE = 8'hA6;
    localparam logic [IDX_W-1:0] IDX_PRIORITY_FOUR = 8'hAC;
    localparam logic [IDX_W-1:0] IDX_PRIORITY_FIVE = 8'hAE;
    localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 8'hD0;
    localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 8'hD2;

    // Implemented bits of each register
    localparam logic [REG_W-1:0] CONTROL_MASK = 16'h801E;
    localparam logic [REG_W-1:0] ENABLE_ONE_MASK = 16'hEA1F;
    localparam logic [REG_W-1:0] ENABLE_ONE_REDUCED = 16'h201F;
    localparam logic [REG_W-1:0] ENABLE_FOUR_MASK = 16'h0106;
    localparam logic [REG_W-1:0] ENABLE_FOUR_REDUCED = 16'h0102;
    localparam logic [REG_W-1:0] ENABLE_FIVE_MASK = 16'h0001;
    localparam logic [REG_W-1:0] PRIORITY_ONE_MASK = 16'h7700;
    localparam logic [REG_W-1:0] PRIORITY_FOUR_MASK = 16'h7777;
    localparam logic [REG_W-1:0] PRIORITY_FIVE_MASK = 16'h0007;
    localparam logic [REG_W-1:0] EVENT_MASK_BITS = 16'h001F;

    // Reset values
    localparam logic [REG_W-1:0] CONTROL_RST = 16'h0000;
    localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
    localparam logic [REG_W-1:0] PRIORITY_ONE_RST = 16'h4400;
    localparam logic [REG_W-1:0] PRIORITY_FOUR_RST = 16'h4444;
    localparam logic [REG_W-1:0] PRIORITY_FIVE_RST = 16'h0004;
    localparam logic [REG_W-1:0] EVENT_RST = 16'h0000;

    // Control register fields; EVT_REQ_BIT is a bit of the event status register
    localparam int NEST_DIS_BIT = 15;
    localparam int ARITH_BIT = 4;
    localparam int ADDRESS_BIT = 3;
    localparam int STACK_BIT = 2;
    localparam int OSC_FAIL_BIT = 1;
    localparam int EVT_REQ_BIT = 4;

    // Source numbering; enable bits in enable register one share these positions
    localparam int SRC_SERIAL_PORT1 = 0;
    localparam int SRC_BUS_COLLISION1 = 1;
    localparam int SRC_COMPARATOR = 2;
    localparam int SRC_CHANGE_NOTIFY = 3;
    localparam int SRC_EXT_IRQ1 = 4;

    // Priority field low bits
    localparam int PRIO_SERIAL_PORT1_LSB = 0;
    localparam int PRIO_BUS_COLLISION1_LSB = 4;
    localparam int PRIO_COMPARATOR_LSB = 8;
    localparam int PRIO_CHANGE_NOTIFY_LSB = 12;
    localparam int PRIO_EXT_IRQ1_LSB = 0;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
endpackage : intc_regs_pkg

// File: verilog/intc_regs.sv
`timescale 1ns/1ps
module intc_regs
    import intc_regs_pkg::*;
#(
    parameter bit REDUCED_VARIANT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic arith_trap_evt,
    input wire logic address_trap_evt,
    input wire logic stack_trap_evt,
    input wire logic osc_fail_trap_evt,
    input wire logic [NUM_SRC-1:0] src_flag,
    output logic nesting_disable,
    output logic core_req,
    output logic [PRIO_W-1:0] core_req_level,
    output logic [SRC_W-1:0] core_req_src,
    output logic irq
);
    logic wait_q;
    logic [DATA_W-1:0] rdata_q;
    logic [REG_W-1:0] ctrl_q, ctrl_d;
    logic [REG_W-1:0] ien1_q, ien1_d;
    logic [REG_W-1:0] ien4_q, ien4_d;
    logic [REG_W-1:0] ien5_q, ien5_d;
    logic [REG_W-1:0] interrupt_priority_one_q, interrupt_priority_one_d;
    logic [REG_W-1:0] interrupt_priority_four_q, interrupt_priority_four_d;
    logic [REG_W-1:0] interrupt_priority_five_q, interrupt_priority_five_d;
    logic [REG_W-1:0] evt_q, evt_d;
    logic [REG_W-1:0] emask_q, emask_d;
    logic req_q, req_d;
    logic [PRIO_W-1:0] lvl_q, lvl_d;
    logic [SRC_W-1:0] src_q, src_d;
    logic irq_q, irq_d;

    // Writes every enabled byte lane; only implemented bits change
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                               input logic [DATA_W-1:0] wd,
                                               input logic [3:0] be,
                                               input logic [REG_W-1:0] impl);
        logic [REG_W-1:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & impl;
        merge = (old & ~lanes) | (wd[REG_W-1:0] & lanes);
    endfunction : merge

    function automatic logic [PRIO_W-1:0] prio_of(input int idx,
                                                  input logic [REG_W-1:0] p4,
                                                  input logic [REG_W-1:0] p5);
        case (idx)
            SRC_SERIAL_PORT1: prio_of = p4[PRIO_SERIAL_PORT1_LSB +: PRIO_W];
            SRC_BUS_COLLISION1: prio_of = p4[PRIO_BUS_COLLISION1_LSB +: PRIO_W];
            SRC_COMPARATOR: prio_of = p4[PRIO_COMPARATOR_LSB +: PRIO_W];
            SRC_CHANGE_NOTIFY: prio_of = p4[PRIO_CHANGE_NOTIFY_LSB +: PRIO_W];
            SRC_EXT_IRQ1: prio_of = p5[PRIO_EXT_IRQ1_LSB +: PRIO_W];
            default: prio_of = PRIO_OFF;
        endcase
    endfunction : prio_of

    // Bus decode; a write is taken at the edge where waitrequest is low
    wire logic [IDX_W-1:0] idx = address[ADDR_W-1:2];
    wire logic aligned = (address[1:0] == 2'h0);
    wire logic wr_go = write && !wait_q;
    wire logic hit_ctrl = aligned && (idx == IDX_CONTROL_ONE);
    wire logic hit_ien1 = aligned && (idx == IDX_ENABLE_ONE);
    wire logic hit_ien4 = aligned && (idx == IDX_ENABLE_FOUR);
    wire logic hit_ien5 = aligned && (idx == IDX_ENABLE_FIVE);
    wire logic hit_interrupt_priority_one = aligned && (idx == IDX_PRIORITY_ONE);
    wire logic hit_interrupt_priority_four = aligned && (idx == IDX_PRIORITY_FOUR);
    wire logic hit_interrupt_priority_five = aligned && (idx == IDX_PRIORITY_FIVE);
    wire logic hit_evt = aligned && (idx == IDX_EVENT_STATUS);
    wire logic hit_emask = aligned && (idx == IDX_EVENT_MASK);
    // Any mapped register; everything else reads zero and drops writes
    wire logic hit_any = hit_ctrl || hit_ien1 || hit_ien4 || hit_ien5 || hit_interrupt_priority_one
        || hit_interrupt_priority_four || hit_interrupt_priority_five || hit_evt || hit_emask;

    wire logic [REG_W-1:0] ien1_impl = REDUCED_VARIANT ? ENABLE_ONE_REDUCED : ENABLE_ONE_MASK;
    wire logic [REG_W-1:0] ien4_impl = REDUCED_VARIANT ? ENABLE_FOUR_REDUCED : ENABLE_FOUR_MASK;

    wire logic [REG_W-1:0] trap_set = ({15'h0000, arith_trap_evt} << ARITH_BIT)
        | ({15'h0000, address_trap_evt} << ADDRESS_BIT)
        | ({15'h0000, stack_trap_evt} << STACK_BIT)
        | ({15'h0000, osc_fail_trap_evt} << OSC_FAIL_BIT);

    // trap flags, set wins over a write
    // only a software write of zero clears them
    assign ctrl_d = (wr_go && hit_ctrl) ? (merge(ctrl_q, writedata, byteenable, CONTROL_MASK)
        | trap_set) : (ctrl_q | trap_set);
    assign ien1_d = (wr_go && hit_ien1) ? merge(ien1_q, writedata, byteenable, ien1_impl) : ien1_q;
    assign ien4_d = (wr_go && hit_ien4) ? merge(ien4_q, writedata, byteenable, ien4_impl) : ien4_q;
    assign ien5_d = (wr_go && hit_ien5)
        ? merge(ien5_q, writedata, byteenable, ENABLE_FIVE_MASK) : ien5_q;
    assign interrupt_priority_one_d = (wr_go && hit_interrupt_priority_one)
        ? merge(interrupt_priority_one_q, writedata, byteenable, PRIORITY_ONE_MASK) : interrupt_priority_one_q;
    assign interrupt_priority_four_d = (wr_go && hit_interrupt_priority_four)
        ? merge(interrupt_priority_four_q, writedata, byteenable, PRIORITY_FOUR_MASK) : interrupt_priority_four_q;
    assign interrupt_priority_five_d = (wr_go && hit_interrupt_priority_five)
        ? merge(interrupt_priority_five_q, writedata, byteenable, PRIORITY_FIVE_MASK) : interrupt_priority_five_q;

    // Per-source pending level; zero means not requesting
    logic [PRIO_W-1:0] pend_lvl [NUM_SRC];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            assign pend_lvl[gi] = (src_flag[gi] && ien1_q[gi])
                ? prio_of(gi, interrupt_priority_four_q, interrupt_priority_five_q) : PRIO_OFF;
        end
    endgenerate

    // Highest level wins; a tie goes to the lower source number
    always_comb begin
        lvl_d = PRIO_OFF;
        src_d = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend_lvl[i] != PRIO_OFF && pend_lvl[i] >= lvl_d) begin
                lvl_d = pend_lvl[i];
                src_d = SRC_W'(i);
            end
        end
    end
    assign req_d = (lvl_d != PRIO_OFF);

    // Events: four trap strokes and a new core request
    wire logic [REG_W-1:0] evt_set = trap_set[ARITH_BIT:OSC_FAIL_BIT] == 4'h0
        ? ({15'h0000, req_d && !req_q} << EVT_REQ_BIT)
        : (({15'h0000, req_d && !req_q} << EVT_REQ_BIT)
        | {12'h000, trap_set[ARITH_BIT:OSC_FAIL_BIT]});
    wire logic [REG_W-1:0] evt_clr = (wr_go && hit_evt)
        ? (merge(16'h0000, writedata, byteenable, EVENT_MASK_BITS)) : 16'h0000;
    // Set beats write-one-to-clear in the same cycle
    assign evt_d = (evt_q & ~evt_clr) | evt_set;
    assign emask_d = (wr_go && hit_emask)
        ? merge(emask_q, writedata, byteenable, EVENT_MASK_BITS) : emask_q;
    assign irq_d = |(evt_d & emask_d);

    // Read mux; unmapped addresses read zero
    wire logic [REG_W-1:0] rsel =
        hit_ctrl ? ctrl_q : hit_ien1 ? ien1_q : hit_ien4 ? ien4_q :
        hit_ien5 ? ien5_q : hit_interrupt_priority_one ? interrupt_priority_one_q : hit_interrupt_priority_four ? interrupt_priority_four_q :
        hit_interrupt_priority_five ? interrupt_priority_five_q : hit_evt ? evt_q : hit_emask ? emask_q : 16'h0000;

    // One wait cycle per access gives the read mux a full cycle into rdata_q
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= !((read || write) && wait_q);
            if (read && wait_q) begin
                rdata_q <= {16'h0000, rsel};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CONTROL_RST;
            ien1_q <= ENABLE_RST;
            ien4_q <= ENABLE_RST;
            ien5_q <= ENABLE_RST;
            interrupt_priority_one_q <= PRIORITY_ONE_RST;
            interrupt_priority_four_q <= PRIORITY_FOUR_RST;
            interrupt_priority_five_q <= PRIORITY_FIVE_RST;
        end else begin
            ctrl_q <= ctrl_d;
            ien1_q <= ien1_d;
            ien4_q <= ien4_d;
            ien5_q <= ien5_d;
            interrupt_priority_one_q <= interrupt_priority_one_d;
            interrupt_priority_four_q <= interrupt_priority_four_d;
            interrupt_priority_five_q <= interrupt_priority_five_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_q <= EVENT_RST;
            emask_q <= EVENT_RST;
            req_q <= 1'b0;
            lvl_q <= PRIO_OFF;
            src_q <= '0;
            irq_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            emask_q <= emask_d;
            req_q <= req_d;
            lvl_q <= lvl_d;
            src_q <= src_d;
            irq_q <= irq_d;
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign nesting_disable = ctrl_q[NEST_DIS_BIT];
    assign core_req = req_q;
    assign core_req_level = lvl_q;
    assign core_req_src = src_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_wait_single_low: assert property (!wait_q |=> wait_q)
        else $error("waitrequest low for more than one cycle");
    a_arith_trap_sets: assert property (arith_trap_evt |=> ctrl_q[ARITH_BIT])
        else $error("arithmetic trap flag not set");
    a_addr_trap_sets: assert property (address_trap_evt |=> ctrl_q[ADDRESS_BIT])
        else $error("address trap flag not set");
    a_stack_flag_holds: assert property (
        ctrl_q[STACK_BIT] && !(wr_go && hit_ctrl) |=> ctrl_q[STACK_BIT])
        else $error("stack trap flag cleared without a write");
    a_osc_trap_sets: assert property (osc_fail_trap_evt |=> ctrl_q[OSC_FAIL_BIT])
        else $error("oscillator trap flag not set");
    a_unimpl_zero: assert property (
        (ctrl_q & ~CONTROL_MASK) == 16'h0000 && (ien5_q & ~ENABLE_FIVE_MASK) == 16'h0000
        && (interrupt_priority_five_q & ~PRIORITY_FIVE_MASK) == 16'h0000)
        else $error("unimplemented bit is set");
    a_variant_bits: assert property ((ien1_q & ~ien1_impl) == 16'h0000
        && (ien4_q & ~ien4_impl) == 16'h0000)
        else $error("variant-absent enable bit is set");
    a_prio_zero_off: assert property (
        interrupt_priority_five_q[PRIO_EXT_IRQ1_LSB +: PRIO_W] == PRIO_OFF |-> pend_lvl[SRC_EXT_IRQ1] == PRIO_OFF)
        else $error("source with priority zero is pending");
    a_enable_gates: assert property (!ien1_q[SRC_COMPARATOR] && !req_q ##1
        !ien1_q[SRC_COMPARATOR] && (interrupt_priority_four_q[PRIO_COMPARATOR_LSB +: PRIO_W] == 3'h7)
        |-> src_q != SRC_W'(SRC_COMPARATOR) || !req_q)
        else $error("disabled comparator forwarded");
    a_req_highest: assert property (
        req_q |-> $past(pend_lvl[src_d]) == lvl_q && lvl_q != PRIO_OFF)
        else $error("forwarded level does not match source");
    a_req_follows: assert property ((src_flag[SRC_EXT_IRQ1] && ien1_q[SRC_EXT_IRQ1]
        && interrupt_priority_five_q[PRIO_EXT_IRQ1_LSB +: PRIO_W] == 3'h7) |=> req_q && lvl_q == 3'h7)
        else $error("priority seven source not forwarded");
    a_nest_out: assert property ((wr_go && hit_ctrl && byteenable[1])
        |=> nesting_disable == $past(writedata[NEST_DIS_BIT]))
        else $error("nesting disable not written");
    a_irq_level: assert property (irq_q == |(evt_q & emask_q))
        else $error("irq does not match masked status");
    // Bus handshake: one wait cycle per access, never more
    a_wait_answers: assert property ((read || write) && wait_q |=> !wait_q)
        else $error("request not answered after one wait cycle");
    a_idle_wait_high: assert property (!read && !write && wait_q |=> wait_q)
        else $error("waitrequest dropped without a request");
    // Reads are latched at the first edge, so the data reflects the old value
    a_read_data: assert property ((read && wait_q && hit_ien5)
        |=> readdata == {16'h0000, $past(ien5_q)})
        else $error("enable five read returned wrong data");
    a_unmapped_read_zero: assert property ((read && wait_q && !hit_any)
        |=> readdata == 32'h00000000)
        else $error("unmapped read returned data");
    // Flags survive until software writes zero; a late trap wins
    a_stack_trap_sets: assert property (stack_trap_evt |=> ctrl_q[STACK_BIT])
        else $error("stack trap flag not set");
    a_addr_flag_holds: assert property (
        ctrl_q[ADDRESS_BIT] && !(wr_go && hit_ctrl) |=> ctrl_q[ADDRESS_BIT])
        else $error("address trap flag cleared without a write");
    a_osc_flag_holds: assert property (
        ctrl_q[OSC_FAIL_BIT] && !(wr_go && hit_ctrl) |=> ctrl_q[OSC_FAIL_BIT])
        else $error("oscillator trap flag cleared without a write");
    // A trap in the write cycle would hide a broken write path, so it is excluded
    a_ctrl_write: assert property (
        wr_go && hit_ctrl && byteenable[0] && trap_set == 16'h0000
        |=> ctrl_q[ARITH_BIT:OSC_FAIL_BIT] == $past(writedata[ARITH_BIT:OSC_FAIL_BIT]))
        else $error("trap flags not written");
    // Bits outside the full-variant masks never hold a one
    a_ien1_bits: assert property ((ien1_q & ~ENABLE_ONE_MASK) == 16'h0000)
        else $error("enable one holds an unimplemented bit");
    a_ien4_bits: assert property ((ien4_q & ~ENABLE_FOUR_MASK) == 16'h0000)
        else $error("enable four holds an unimplemented bit");
    a_ien5_bits: assert property ((ien5_q & ~ENABLE_FIVE_MASK) == 16'h0000)
        else $error("enable five holds an unimplemented bit");
    a_ipc_bits: assert property ((interrupt_priority_one_q & ~PRIORITY_ONE_MASK) == 16'h0000
        && (interrupt_priority_four_q & ~PRIORITY_FOUR_MASK) == 16'h0000)
        else $error("priority register holds an unimplemented bit");
    // Writes land at the edge where waitrequest is low
    a_interrupt_priority_five_write: assert property ((wr_go && hit_interrupt_priority_five && byteenable[0])
        |=> interrupt_priority_five_q[PRIO_EXT_IRQ1_LSB +: PRIO_W] == $past(writedata[PRIO_EXT_IRQ1_LSB +: PRIO_W]))
        else $error("external irq 1 priority not written");
    a_ien_write: assert property ((wr_go && hit_ien1 && byteenable[0])
        |=> ien1_q[SRC_EXT_IRQ1] == $past(writedata[SRC_EXT_IRQ1]))
        else $error("enable bit not written");
    a_idle_no_level: assert property (!req_q |-> lvl_q == PRIO_OFF && src_q == '0)
        else $error("level shown without a request");
    a_evt_trap_sets: assert property (arith_trap_evt |=> evt_q[ARITH_BIT - OSC_FAIL_BIT])
        else $error("arithmetic trap status bit not set");
    a_evt_req_sets: assert property (req_d && !req_q |=> evt_q[EVT_REQ_BIT])
        else $error("new request did not set its status bit");
    // Status bits are sticky: only a write of one may take them down
    a_evt_sticky: assert property (evt_q[EVT_REQ_BIT] && !(wr_go && hit_evt)
        |=> evt_q[EVT_REQ_BIT])
        else $error("request status bit lost without a clear");
    a_evt_clear: assert property (wr_go && hit_evt && byteenable[0]
        && writedata[EVT_REQ_BIT] && !(req_d && !req_q) |=> !evt_q[EVT_REQ_BIT])
        else $error("request status bit not cleared by a write of one");

    // The winner's level is at least that of every pending source
    genvar gj;
    generate
        for (gj = 0; gj < NUM_SRC; gj++) begin : g_chk
            a_level_highest: assert property (@(posedge clk) disable iff (!rst_n)
                pend_lvl[gj] != PRIO_OFF |=> req_q && lvl_q >= $past(pend_lvl[gj]))
                else $error("a higher pending source was passed over");
            a_disabled_idle: assert property (@(posedge clk) disable iff (!rst_n)
                !ien1_q[gj] |-> pend_lvl[gj] == PRIO_OFF)
                else $error("disabled source is pending");
        end
    endgenerate

    c_trap_seen: cover property (arith_trap_evt ##1 ctrl_q[ARITH_BIT]);
    c_req_raised: cover property (!req_q ##1 req_q ##1 irq_q);
    c_write_taken: cover property (write && wait_q ##1 write && !wait_q);
    c_read_taken: cover property (read && wait_q ##1 read && !wait_q);
    c_tie_break: cover property (req_q && src_q == '0 && pend_lvl[1] == lvl_q);
endmodule : intc_regs

// File: verif/core_model.sv
`timescale 1ns/1ps
module core_model
    import intc_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic core_req,
    input wire logic [PRIO_W-1:0] core_req_level,
    output logic [3:0] trap_evt,
    output logic [PRIO_W-1:0] taken_level
);
    logic req_q;
    initial trap_evt = 4'h0;
    // One-cycle fault strokes, layout arith, address, stack, osc from msb down
    task automatic raise_trap(input logic [3:0] which);
        @(posedge clk);
        trap_evt <= which;
        @(posedge clk);
        trap_evt <= 4'h0;
    endtask : raise_trap
    // Takes a request once, on its rising edge, like a vectoring core
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 1'b0;
            taken_level <= 3'h0;
        end else begin
            req_q <= core_req;
            if (core_req && !req_q) begin
                taken_level <= core_req_level;
            end
        end
    end
endmodule : core_model

// File: verif/tb_intc_regs.sv
`timescale 1ns/1ps
module tb_intc_regs
    import intc_regs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [3:0] byteenable = 4'h3;
    logic [NUM_SRC-1:0] src_flag = '0;
    logic [DATA_W-1:0] readdata, readdata_r, rd_q, rd2_q;
    logic waitrequest, nesting_disable, core_req, irq;
    logic [PRIO_W-1:0] core_req_level, taken_level;
    logic [SRC_W-1:0] core_req_src;
    logic [3:0] trap_evt;
    int num_errors = 0;
    int checked = 0;
    logic [IDX_W-1:0] idx_t [7] = '{IDX_CONTROL_ONE, IDX_ENABLE_ONE, IDX_ENABLE_FOUR,
        IDX_ENABLE_FIVE, IDX_PRIORITY_ONE, IDX_PRIORITY_FOUR, IDX_PRIORITY_FIVE};
    logic [REG_W-1:0] msk_t [7] = '{CONTROL_MASK, ENABLE_ONE_MASK, ENABLE_FOUR_MASK,
        ENABLE_FIVE_MASK, PRIORITY_ONE_MASK, PRIORITY_FOUR_MASK, PRIORITY_FIVE_MASK};
    logic [REG_W-1:0] red_t [7] = '{CONTROL_MASK, ENABLE_ONE_REDUCED, ENABLE_FOUR_REDUCED,
        ENABLE_FIVE_MASK, PRIORITY_ONE_MASK, PRIORITY_FOUR_MASK, PRIORITY_FIVE_MASK};
    logic [REG_W-1:0] rst_t [7] = '{CONTROL_RST, ENABLE_RST, ENABLE_RST, ENABLE_RST,
        PRIORITY_ONE_RST, PRIORITY_FOUR_RST, PRIORITY_FIVE_RST};

    always #20 clk = ~clk;

    intc_regs uut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .arith_trap_evt(trap_evt[3]),
        .address_trap_evt(trap_evt[2]), .stack_trap_evt(trap_evt[1]),
        .osc_fail_trap_evt(trap_evt[0]), .src_flag(src_flag),
        .nesting_disable(nesting_disable), .core_req(core_req),
        .core_req_level(core_req_level), .core_req_src(core_req_src), .irq(irq));
    // Shares the bus so both variants answer in the same cycle
    intc_regs #(.REDUCED_VARIANT(1'b1)) uut_reduced (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata_r), .waitrequest(),
        .arith_trap_evt(trap_evt[3]), .address_trap_evt(trap_evt[2]),
        .stack_trap_evt(trap_evt[1]), .osc_fail_trap_evt(trap_evt[0]), .src_flag(src_flag),
        .nesting_disable(), .core_req(), .core_req_level(), .core_req_src(), .irq());
    core_model model (.clk(clk), .rst_n(rst_n), .core_req(core_req),
        .core_req_level(core_req_level), .trap_evt(trap_evt), .taken_level(taken_level));

    function automatic logic [ADDR_W-1:0] ad(input logic [IDX_W-1:0] idx);
        return {idx, 2'b00};
    endfunction : ad

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
            input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [REG_W-1:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= {16'h0000, d};
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("wrong value at %0t: no bus answer", $time);
        end
        rd_q = readdata;
        rd2_q = readdata_r;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e,
            input logic [REG_W-1:0] e2);
        bus(1'b0, a, 16'h0000, 4'h3);
        check(rd_q, {16'h0000, e}, "register read");
        check(rd2_q, {16'h0000, e2}, "reduced register read");
    endtask : rd

    task automatic chk_req(input logic r, input logic [2:0] l, input logic [2:0] s);
        repeat (2) @(posedge clk);
        check({25'h0, core_req, core_req_level, core_req_src}, {25'h0, r, l, s}, "core request");
    endtask : chk_req

    task automatic test_reset;
        check({28'h0, core_req, irq, nesting_disable, waitrequest}, 32'h1, "idle outputs");
        for (int i = 0; i < 7; i++) begin
            rd(ad(idx_t[i]), rst_t[i], rst_t[i]);
        end
    endtask : test_reset

    task automatic test_access;
        bus(1'b1, ad(IDX_PRIORITY_FOUR), 16'hFFFF, 4'h1);
        rd(ad(IDX_PRIORITY_FOUR), 16'h4477, 16'h4477);
        for (int i = 0; i < 7; i++) begin
            wr(ad(idx_t[i]), 16'hFFFF);
            rd(ad(idx_t[i]), msk_t[i], red_t[i]);
        end
        check({31'h0, nesting_disable}, 32'h1, "nesting disable set");
        for (int i = 0; i < 7; i++) begin
            wr(ad(idx_t[i]), 16'h0000);
            rd(ad(idx_t[i]), 16'h0000, 16'h0000);
        end
        check({31'h0, nesting_disable}, 32'h0, "nesting disable clear");
        wr(ad(8'h81), 16'hFFFF);
        rd(ad(8'h81), 16'h0000, 16'h0000);
        wr({IDX_CONTROL_ONE, 2'b01}, 16'hFFFF);
        rd(ad(IDX_CONTROL_ONE), 16'h0000, 16'h0000);
    endtask : test_access

    task automatic test_traps;
        logic [REG_W-1:0] flag_e;
        wr(ad(IDX_EVENT_MASK), 16'h0000);
        wr(ad(IDX_EVENT_STATUS), 16'h001F);
        model.raise_trap(4'h8);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0, "masked irq");
        wr(ad(IDX_EVENT_MASK), 16'h001F);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        wr(ad(IDX_CONTROL_ONE), 16'h0000);
        for (int b = 0; b < 4; b++) begin
            model.raise_trap(4'h1 << b);
            repeat (3) @(posedge clk);
            // Flag must outlive the one-cycle stroke
            flag_e = 16'h0002 << b;
            rd(ad(IDX_CONTROL_ONE), flag_e, flag_e);
            check({31'h0, irq}, 32'h1, "trap irq");
            wr(ad(IDX_CONTROL_ONE), 16'h0000);
            rd(ad(IDX_CONTROL_ONE), 16'h0000, 16'h0000);
            wr(ad(IDX_EVENT_STATUS), 16'h000F);
            repeat (2) @(posedge clk);
            check({31'h0, irq}, 32'h0, "irq after clear");
        end
    endtask : test_traps

    task automatic test_requests;
        wr(ad(IDX_EVENT_MASK), 16'h0000);
        wr(ad(IDX_ENABLE_ONE), 16'h001F);
        @(posedge clk);
        src_flag <= 5'h1F;
        chk_req(1'b0, 3'h0, 3'h0);
        wr(ad(IDX_PRIORITY_FIVE), 16'h0007);
        wr(ad(IDX_PRIORITY_FOUR), 16'h1234);
        chk_req(1'b1, 3'h7, 3'h4);
        wr(ad(IDX_PRIORITY_FIVE), 16'h0000);
        chk_req(1'b1, 3'h4, 3'h0);
        wr(ad(IDX_ENABLE_ONE), 16'h001E);
        chk_req(1'b1, 3'h3, 3'h1);
        wr(ad(IDX_PRIORITY_FOUR), 16'h3333);
        wr(ad(IDX_ENABLE_ONE), 16'h001F);
        chk_req(1'b1, 3'h3, 3'h0);
        @(posedge clk);
        src_flag <= 5'h00;
        chk_req(1'b0, 3'h0, 3'h0);
        check({29'h0, taken_level}, 32'h7, "level taken by core");
        rd(ad(IDX_EVENT_STATUS), 16'h0010, 16'h0010);
        wr(ad(IDX_EVENT_MASK), 16'h0010);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1, "request irq");
        wr(ad(IDX_EVENT_STATUS), 16'h0010);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0, "request irq cleared");
    endtask : test_requests

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_access();
        test_traps();
        test_requests();
        complete_run();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (8000) @(posedge clk);
        num_errors++;
        $display("wrong value at %0t: run did not finish", $time);
        complete_run();
    end
endmodule : tb_intc_regs
